// ==== rtl/cio_port_bank.sv ====
`timescale 1ns/1ps
module cio_port_bank #(
    parameter int W = 8                       // pins per full port
) (
    input  wire logic             clock_i,          // 200 MHz clock
    input  wire logic             sys_rst_i,        // sync reset, high
    input  wire logic [7:0]       host_addr_i,      // register offset
    input  wire logic             host_cs_i,        // io space select
    input  wire logic             host_wr_i,        // write strobe
    input  wire logic             host_rd_i,        // read strobe
    input  wire logic [7:0]       host_wdata_i,     // write data
    output logic [7:0]            host_rdata_o,     // read data
    input  wire logic             host_address_latch_strobe_i, // ale
    input  wire logic [7:0]       host_addr_low_i,  // latched A7-A0
    input  wire logic             nonmux_bus_i,     // non-mux host
    input  wire logic             data_port_i,      // port A data bus
    input  wire logic [7:0]       host_data_out_i,  // host data bus
    input  wire logic             host_data_oe_i,   // host drives data
    input  wire logic             peripheral_select_zero_i, // sel 0
    input  wire logic             peripheral_select_one_i,  // sel 1
    input  wire logic             jtag_enable_i,    // port C to jtag
    input  wire logic [7:0]       jtag_out_i,       // jtag pin values
    input  wire logic [7:0]       jtag_oe_i,        // jtag pin enables
    input  wire logic [3:0][7:0]  array_oe_i,       // enable terms
    input  wire logic [1:0][7:0]  array_cell_d_i,   // array cell next
    input  wire logic [2:0][7:0]  in_cell_latch_i,  // 1 = ale capture
    input  wire logic [3:0][7:0]  pin_in_i,         // pin levels
    output logic [3:0][7:0]       pin_out_o,        // pin drive value
    output logic [3:0][7:0]       pin_oe_o,         // pin enables
    output logic [3:0][7:0]       open_drain_o,     // open drain select
    output logic [3:0][7:0]       fast_slew_o,      // fast slew select
    output logic [1:0][7:0]       out_cell_o,       // output cells
    output logic [2:0][7:0]       in_cell_o         // to input bus
);

    // ------------------------------------------------------------
    // register map, offsets within the io register space
    // ------------------------------------------------------------
    // pin input      00 01 10 11   live pin level, read only
    // mode select    02 03         ports A and B only
    // output latch   04 05 14 15   data driven when enabled
    // direction      06 07 16 17   1 drives the pin
    // drive select   08 09 18 19   open drain or slew per bit
    // input cells    0A 0B 1A      capture or follow per bit
    // enable status  0C 0D 1C      registered pin enables
    // output cells   20 21         masked host load
    // cell mask      22 23         1 blocks host load
    // peripheral     2C            bit 7 turns port A into buffer
    // every other offset reads 00 and swallows writes, so a host
    // probing the space never sees stale bus data
    // ports C and D sit at offset plus 10 hex, with no mode
    // register; their mode offsets read zero
    //
    // timing: a write lands on the taking edge; pins follow one
    // cycle later because the driver values are registered too.
    // read data stands for exactly one cycle after the read edge
    // and returns to zero, which keeps the bus quiet when idle.
    //
    // override order on port A: data bus, then peripheral buffer,
    // then ordinary io. port C may be lent to the programming port
    // at any time; its own configuration is kept and returns as
    // soon as the programming port lets go.
    //
    // pin arrays are indexed 0 to 3 for ports A to D; port D has
    // three pins, so bits 7 to 3 of its entries stay zero
    //
    // the enable status byte shows what the pins really do, so
    // it reports the data bus, buffer and programming overrides
    // as well as the direction register
    //
    // limitation: the input cell capture is a clocked sample of a
    // level strobe, not a true latch; a strobe shorter than one
    // clock cycle may be missed

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // port index of an offset pair; C and D sit one step up
    // bit 0 picks the odd port of a pair, bit 4 the upper pair,
    // so the two bits together number the ports A to D
    function automatic logic [1:0] port_of(input logic [7:0] a);
        logic [1:0] p;
        p = {a[4], a[0]};
        return p;
    endfunction : port_of

    // base offset with port bits stripped
    // stripping bits 4 and 0 leaves one offset per register
    // kind, so one case decode serves all four ports
    function automatic logic [7:0] base_of(input logic [7:0] a);
        logic [7:0] b;
        b = a & ~(cio_pkg::PORT_CD_STEP | 8'h01);
        return b;
    endfunction : base_of

    // mask of real bits in a port, D has three pins
    // used on writes and drivers alike, so an absent pin can
    // never be driven by a stale bit
    function automatic logic [7:0] pin_mask(input logic [1:0] p);
        logic [7:0] m;
        m = (p == 2'd3) ? cio_pkg::PORT_D_MASK : 8'hFF;
        return m;
    endfunction : pin_mask

    // all state sits in one struct: one comb copy, one register,
    // so reset clears every flop in a single assignment and no
    // field can be forgotten

    cio_pkg::cio_state_s state_reg;
    cio_pkg::cio_state_s state_next;

    // decoded access: which port and which register kind
    logic [1:0] acc_port;
    logic [7:0] acc_base;
    logic       wr_hit;
    logic       rd_hit;

    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------
    // strobes are levels: each cycle with select and write high
    // is one more write, so a host must drop them between cycles
    assign acc_port = port_of(host_addr_i);
    assign acc_base = base_of(host_addr_i);
    assign wr_hit   = host_cs_i & host_wr_i;
    assign rd_hit   = host_cs_i & host_rd_i;
    // a read and a write in one cycle are both taken; the read
    // returns the value from before the write

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [7:0] addr_pins;
        logic [7:0] dir_any;
        logic [7:0] drv;
        logic       psel;
        state_next = state_reg;
        addr_pins  = 8'h00;
        dir_any    = 8'h00;
        drv        = 8'h00;
        // either select opens the peripheral buffer
        psel       = peripheral_select_zero_i | peripheral_select_one_i;

        // register writes; masked so absent bits stay zero
        // port D keeps only three flops per register, and the mode
        // and mask writes are dropped for ports without them
        if (wr_hit)
        begin
            case (acc_base)
                cio_pkg::OFS_MODE_SELECT:
                    if (acc_port < 2'd2)
                        state_next.port[acc_port].mode_select =
                            host_wdata_i;
                cio_pkg::OFS_DIRECTION:
                    state_next.port[acc_port].direction =
                        host_wdata_i & pin_mask(acc_port);
                cio_pkg::OFS_DRIVE_SELECT:
                    state_next.port[acc_port].drive_select =
                        host_wdata_i & pin_mask(acc_port);
                cio_pkg::OFS_OUT_LATCH:
                    state_next.port[acc_port].out_latch =
                        host_wdata_i & pin_mask(acc_port);
                cio_pkg::OFS_CELL_MASK:
                    if (acc_port < 2'd2)
                        state_next.cell_mask[acc_port[0]] =
                            host_wdata_i;
                cio_pkg::OFS_PERIPH_MODE:
                    if (acc_port == 2'd0)
                        state_next.periph_mode = host_wdata_i;
                default: ;
            endcase
        end

        // output cells: array runs them, host loads unmasked bits
        // a host load wins over the array for one cycle only; the
        // array takes the cell back on the next edge
        for (int g = 0; g < 2; g++)
        begin
            state_next.out_cell[g] = array_cell_d_i[g];
            if (wr_hit && acc_base == cio_pkg::OFS_OUT_CELL
                && acc_port == 2'(g))
                state_next.out_cell[g] =
                    (host_wdata_i & ~state_reg.cell_mask[g])
                  | (array_cell_d_i[g] & state_reg.cell_mask[g]);
        end

        // input cells latch pins on the strobe, else transparent
        // the strobe is a level, so a long strobe keeps the cells
        // open; the value of its last high edge is kept
        for (int c = 0; c < 3; c++)
            for (int b = 0; b < W; b++)
                if (!in_cell_latch_i[c][b] || host_address_latch_strobe_i)
                    state_next.in_cell[c][b] = pin_in_i[c][b];

        // pin drivers per port
        // direction and enable term are ored, so the host cannot
        // turn off a pin that the array drives; open drain and
        // slew bits act only where the pin can use them
        for (int p = 0; p < 4; p++)
        begin
            // port D has no enable term; A-C or it in
            dir_any = state_reg.port[p].direction
                    | ((p < 3) ? array_oe_i[p] : 8'h00);
            dir_any = dir_any & pin_mask(2'(p));
            // latched address: 8-bit mux uses A and B, non-mux only B
            // pins in io mode keep the output latch value instead
            addr_pins = ((p == 1) || (p == 0 && !nonmux_bus_i))
                      ? host_addr_low_i : 8'h00;
            for (int b = 0; b < W; b++)
                state_next.pin_out[p][b] =
                    (state_reg.port[p].mode_select[b] && p < 2)
                    ? addr_pins[b]
                    : state_reg.port[p].out_latch[b];
            state_next.pin_oe[p] = dir_any;
            drv = state_reg.port[p].drive_select & pin_mask(2'(p));
            state_next.open_drain[p] = drv
                & ((p == 2) ? cio_pkg::OPEN_DRAIN_C
                  : (p < 2) ? cio_pkg::OPEN_DRAIN_AB
                  : 8'h00);
            state_next.fast_slew[p] = drv
                & ((p == 2) ? 8'h00
                  : (p < 2) ? ~cio_pkg::OPEN_DRAIN_AB
                  : cio_pkg::PORT_D_MASK);
        end

        // port A taken over by host data bus
        // the data bus wins over the peripheral buffer; both leave
        // the port registers untouched for when the mode ends
        if (data_port_i)
        begin
            state_next.pin_out[0] = host_data_out_i;
            state_next.pin_oe[0]  = {8{host_data_oe_i}};
        end
        else if (state_reg.periph_mode[cio_pkg::PERIPH_BIT])
        begin
            state_next.pin_out[0] = host_data_out_i;
            state_next.pin_oe[0]  = {8{psel & host_data_oe_i}};
        end

        // programming port borrows all of port C while enabled
        // open drain is dropped so the programming signals see a
        // full push-pull driver while they own the pins
        if (jtag_enable_i)
        begin
            state_next.pin_out[2] = jtag_out_i;
            state_next.pin_oe[2]  = jtag_oe_i;
            state_next.open_drain[2] = 8'h00;
        end

        // read mux, registered one cycle behind the strobe
        // idle cycles return zero, so a bus that ors several
        // sources never sees stale data from this block
        // enable status and input cell reads stop at port C, output cell and mask reads at B
        state_next.rd_data = 8'h00;
        if (rd_hit)
        begin
            case (acc_base)
                cio_pkg::OFS_PIN_INPUT:
                    state_next.rd_data = pin_in_i[acc_port]
                        & pin_mask(acc_port);
                cio_pkg::OFS_MODE_SELECT:
                    state_next.rd_data = (acc_port < 2'd2)
                        ? state_reg.port[acc_port].mode_select : 8'h00;
                cio_pkg::OFS_DIRECTION:
                    state_next.rd_data = state_reg.port[acc_port].direction;
                cio_pkg::OFS_DRIVE_SELECT:
                    state_next.rd_data =
                        state_reg.port[acc_port].drive_select;
                cio_pkg::OFS_OUT_LATCH:
                    state_next.rd_data =
                        state_reg.port[acc_port].out_latch;
                cio_pkg::OFS_IN_CELL:
                    state_next.rd_data = (acc_port < 2'd3)
                        ? state_reg.in_cell[acc_port] : 8'h00;
                cio_pkg::OFS_ENABLE_STAT:
                    state_next.rd_data = (acc_port < 2'd3)
                        ? state_reg.pin_oe[acc_port] : 8'h00;
                cio_pkg::OFS_OUT_CELL:
                    state_next.rd_data = (acc_port < 2'd2)
                        ? state_reg.out_cell[acc_port[0]] : 8'h00;
                cio_pkg::OFS_CELL_MASK:
                    state_next.rd_data = (acc_port < 2'd2)
                        ? state_reg.cell_mask[acc_port[0]] : 8'h00;
                cio_pkg::OFS_PERIPH_MODE:
                    state_next.rd_data = (acc_port == 2'd0)
                        ? state_reg.periph_mode : 8'h00;
                default:
                    state_next.rd_data = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // synchronous reset only; every flop, outputs included,
    // reads zero from the first edge with reset high
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    // outputs straight from flops
    // no gate sits between a flop and a pin, so pin timing is
    // set by the clock alone
    assign host_rdata_o = state_reg.rd_data;
    assign pin_out_o    = state_reg.pin_out;
    assign pin_oe_o     = state_reg.pin_oe;
    assign open_drain_o = state_reg.open_drain;
    assign fast_slew_o  = state_reg.fast_slew;
    assign out_cell_o   = state_reg.out_cell;
    assign in_cell_o    = state_reg.in_cell;

endmodule : cio_port_bank

// ==== rtl/cio_pkg.sv ====
package cio_pkg;

    // ------------------------------------------------------------
    // register offsets within the io register space
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_PIN_INPUT    = 8'h00; // port A base
    localparam logic [7:0] OFS_MODE_SELECT  = 8'h02;
    localparam logic [7:0] OFS_OUT_LATCH    = 8'h04;
    localparam logic [7:0] OFS_DIRECTION    = 8'h06;
    localparam logic [7:0] OFS_DRIVE_SELECT = 8'h08;
    localparam logic [7:0] OFS_IN_CELL      = 8'h0A;
    localparam logic [7:0] OFS_ENABLE_STAT  = 8'h0C;
    localparam logic [7:0] OFS_OUT_CELL     = 8'h20; // A=20,B=21
    localparam logic [7:0] OFS_CELL_MASK    = 8'h22; // A=22,B=23
    localparam logic [7:0] OFS_PERIPH_MODE  = 8'h2C;
    localparam logic [7:0] PORT_CD_STEP     = 8'h10; // C,D at +10,+11

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int         PERIPH_BIT       = 7;
    localparam logic [7:0] CFG_RESET        = 8'h00;
    localparam logic [7:0] PORT_D_MASK      = 8'h07;
    localparam logic [7:0] OPEN_DRAIN_AB    = 8'hF0;
    localparam logic [7:0] OPEN_DRAIN_C     = 8'hFF;

    typedef struct packed {
        logic [7:0] mode_select;
        logic [7:0] direction;
        logic [7:0] drive_select;
        logic [7:0] out_latch;
    } cio_port_s;

    typedef struct packed {
        cio_port_s [3:0] port;          // 0=A 1=B 2=C 3=D
        logic [1:0][7:0] out_cell;      // cell groups A/B
        logic [1:0][7:0] cell_mask;
        logic [2:0][7:0] in_cell;       // ports A,B,C
        logic [7:0]      periph_mode;
        logic [7:0]      rd_data;
        logic [3:0][7:0] pin_out;
        logic [3:0][7:0] pin_oe;
        logic [3:0][7:0] open_drain;
        logic [3:0][7:0] fast_slew;
    } cio_state_s;

endpackage : cio_pkg

// ==== test/cio_port_bank_checker.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// port bank checks
// ----------------------------------------
module cio_port_bank_checker (
    input wire logic            clock_i,         // clk
    input wire logic            sys_rst_i,       // rst
    input wire logic [7:0]      host_addr_i,     // offset
    input wire logic            host_cs_i,       // select
    input wire logic            host_wr_i,       // write
    input wire logic            host_rd_i,       // read
    input wire logic [7:0]      host_wdata_i,    // wdata
    input wire logic [7:0]      host_rdata_o,    // rdata
    input wire logic [3:0][7:0] array_oe_i,      // terms
    input wire logic [2:0][7:0] in_cell_latch_i, // capture
    input wire logic [3:0][7:0] pin_in_i,        // pins
    input wire logic [3:0][7:0] pin_oe_o,        // enables
    input wire logic [3:0][7:0] open_drain_o,    // od
    input wire logic [3:0][7:0] fast_slew_o,     // slew
    input wire logic [2:0][7:0] in_cell_o        // cells
);
    logic wr_ok; // any host write
    assign wr_ok = host_cs_i && host_wr_i;
    // one clock domain, so one default clock and reset
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);
    property p_rst_clear;
        $fell(sys_rst_i) |-> host_rdata_o == 8'h00 && pin_oe_o == '0;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("reset");
    property p_rd_idle;
        !(host_cs_i && host_rd_i) |=> host_rdata_o == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata");
    property p_d_narrow;
        pin_oe_o[3][7:3] == 5'h00 && fast_slew_o[3][7:3] == 5'h00;
    endproperty
    a_d_narrow: assert property (p_d_narrow) else $error("port d");
    property p_drive_map;
        open_drain_o[0][3:0] == 4'h0 && fast_slew_o[2] == 8'h00;
    endproperty
    a_drive_map: assert property (p_drive_map) else $error("map");
    property p_dir_b;
        wr_ok && host_addr_i == 8'h07 ##1 !(wr_ok && host_addr_i == 8'h07)
        |=> pin_oe_o[1] == ($past(host_wdata_i, 2) | $past(array_oe_i[1]));
    endproperty
    a_dir_b: assert property (p_dir_b) else $error("dir b");
    property p_od_c;
        wr_ok && host_addr_i == 8'h18 |-> ##2
        open_drain_o[2] == $past(host_wdata_i, 2);
    endproperty
    a_od_c: assert property (p_od_c) else $error("open drain");
    property p_slew_a;
        wr_ok && host_addr_i == 8'h08 |-> ##2
        fast_slew_o[0] == ($past(host_wdata_i, 2) & 8'h0F);
    endproperty
    a_slew_a: assert property (p_slew_a) else $error("slew");
    property p_in_follow;
        1'b1 |=> (in_cell_o[2] & ~$past(in_cell_latch_i[2]))
        == ($past(pin_in_i[2]) & ~$past(in_cell_latch_i[2]));
    endproperty
    a_in_follow: assert property (p_in_follow) else $error("cell");
    c_dir_b: cover property (wr_ok && host_addr_i == 8'h07);
    c_read: cover property (host_cs_i && host_rd_i);
    c_latch: cover property (in_cell_latch_i[2] != 8'h00);
endmodule : cio_port_bank_checker

// ==== test/cio_pin_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// board wiring beyond the pins
// ----------------------------------------
module cio_pin_model (
    input  wire logic [3:0][7:0] pin_out_i, // device value
    input  wire logic [3:0][7:0] pin_oe_i,  // device enable
    input  wire logic [3:0][7:0] od_i,      // open drain
    input  wire logic [3:0][7:0] ext_i,     // far level
    output logic      [3:0][7:0] pin_in_o   // wire level
);
    // open drain wire-ands with the far side, so a 1 only releases
    assign pin_in_o = (pin_oe_i & ~od_i & pin_out_i)
        | (pin_oe_i & od_i & pin_out_i & ext_i) | (~pin_oe_i & ext_i);
endmodule : cio_pin_model

// ==== test/cio_port_bank_test.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// port bank bench
// ----------------------------------------
module cio_port_bank_test;
    logic            clock_i, sys_rst_i, host_cs_i, host_wr_i, host_rd_i;
    logic            ale, nonmux, peripheral_select_zero, hoe;
    logic            dport, peripheral_select_one, jen;
    logic [7:0]      host_addr_i, host_wdata_i, host_rdata_o, alow, hdata;
    logic [3:0][7:0] aoe, pin_in, pin_out, pin_oe, od, slew, ext;
    logic [1:0][7:0] cell_d, out_cell;
    logic [2:0][7:0] latch, in_cell;
    int              error_cnt, check_count;
    logic [23:0]     tbl [17] = '{
        24'h02A5A5, 24'h03A5A5, 24'h12A500,
        24'h06A5A5, 24'h07A5A5, 24'h16A5A5, 24'h17A505,
        24'h08A5A5, 24'h09A5A5, 24'h18A5A5, 24'h19A505,
        24'h04FFFF, 24'h05C3C3, 24'h143C3C,
        24'h22A5A5, 24'h23A5A5, 24'h3FA500};
    cio_port_bank dut (.clock_i, .sys_rst_i, .host_addr_i, .host_cs_i,
        .host_wr_i, .host_rd_i, .host_wdata_i, .host_rdata_o,
        .host_address_latch_strobe_i(ale), .host_addr_low_i(alow),
        .nonmux_bus_i(nonmux), .data_port_i(dport), .host_data_out_i(hdata),
        .host_data_oe_i(hoe), .peripheral_select_zero_i(peripheral_select_zero),
        .peripheral_select_one_i(peripheral_select_one), .jtag_enable_i(jen),
        .jtag_out_i(8'hC3), .jtag_oe_i(8'h0F), .array_oe_i(aoe),
        .array_cell_d_i(cell_d), .in_cell_latch_i(latch), .pin_in_i(pin_in),
        .pin_out_o(pin_out), .pin_oe_o(pin_oe), .open_drain_o(od),
        .fast_slew_o(slew), .out_cell_o(out_cell), .in_cell_o(in_cell));
    cio_pin_model u_pins (.pin_out_i(pin_out), .pin_oe_i(pin_oe),
        .od_i(od), .ext_i(ext), .pin_in_o(pin_in));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge clock_i);
    endtask : tick
    // request held from falling edge through the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        {host_cs_i, host_wr_i, host_addr_i, host_wdata_i} = {2'b11, a, d};
        @(posedge clock_i);
        @(negedge clock_i);
        {host_cs_i, host_wr_i} = 2'b00;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock_i);
        {host_cs_i, host_rd_i, host_addr_i} = {2'b11, a};
        @(posedge clock_i);
        @(negedge clock_i);
        check(host_rdata_o, exp);
        {host_cs_i, host_rd_i} = 2'b00;
    endtask : rd
    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    // free running 200 MHz clock
    initial
    begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    // whole run is about 150 cycles, so this only catches a hang
    initial
    begin
        #50000;
        error_cnt++;
        stop_test();
    end
    // main sequence
    initial
    begin
        {sys_rst_i, host_cs_i, host_wr_i, host_rd_i} = 4'h8;
        {ale, nonmux, peripheral_select_zero, hoe, host_addr_i, host_wdata_i} = '0;
        {alow, hdata, aoe, latch} = {8'h3C, 8'h00, 32'h0, 24'h0};
        {cell_d, ext} = {16'h3333, 32'h005A0000};
        {dport, peripheral_select_one, jen} = 3'b000;
        repeat (8) @(posedge clock_i);
        @(negedge clock_i);
        sys_rst_i = 1'b0;
        foreach (tbl[i]) rd(tbl[i][23:16], 8'h00);
        foreach (tbl[i]) wr(tbl[i][23:16], tbl[i][15:8]);
        foreach (tbl[i]) rd(tbl[i][23:16], tbl[i][7:0]);
        check(pin_oe[1], 8'hA5);
        check(pin_oe[3], 8'h05);
        check(od[0], 8'hA0);
        check(slew[0], 8'h05);
        check(od[2], 8'hA5);
        check(slew[3], 8'h05);
        check(pin_out[1], 8'h66);
        check(pin_out[0], 8'h7E);
        nonmux = 1'b1;
        tick(2);
        check(pin_out[0], 8'h5A);
        check(pin_out[1], 8'h66);
        aoe = 32'hFF0F0000;
        tick(2);
        check(pin_oe[2], 8'hAF);
        check(pin_oe[3], 8'h05);
        rd(8'h1C, 8'hAF);
        rd(8'h10, 8'h58);
        rd(8'h1A, 8'h58);
        latch[2] = 8'hFF;
        tick(1);
        ale = 1'b1;
        tick(1);
        ale = 1'b0;
        ext[2] = 8'hA0;
        rd(8'h10, 8'h28);
        rd(8'h1A, 8'h58);
        wr(8'h20, 8'hCC);
        check(out_cell[0], 8'h69);
        tick(1);
        check(out_cell[0], 8'h33);
        {hdata, hoe} = {8'h96, 1'b1};
        wr(8'h2C, 8'h80);
        tick(1);
        check(pin_oe[0], 8'h00);
        peripheral_select_zero = 1'b1;
        tick(2);
        check(pin_oe[0], 8'hFF);
        check(pin_out[0], 8'h96);
        rd(8'h2C, 8'h80);
        peripheral_select_zero = 1'b0;
        tick(2);
        check(pin_oe[0], 8'h00);
        peripheral_select_one = 1'b1;
        tick(2);
        check(pin_oe[0], 8'hFF);
        {dport, peripheral_select_one, hdata} = {1'b1, 1'b0, 8'h3C};
        tick(2);
        check(pin_oe[0], 8'hFF);
        check(pin_out[0], 8'h3C);
        {dport, jen} = 2'b01;
        tick(2);
        check(pin_out[2], 8'hC3);
        check(pin_oe[2], 8'h0F);
        check(od[2], 8'h00);
        jen = 1'b0;
        sys_rst_i = 1'b1;
        tick(2);
        sys_rst_i = 1'b0;
        rd(8'h06, 8'h00);
        stop_test();
    end
endmodule : cio_port_bank_test
bind cio_port_bank cio_port_bank_checker u_chk (.clock_i, .sys_rst_i,
    .host_addr_i, .host_cs_i, .host_wr_i, .host_rd_i, .host_wdata_i,
    .host_rdata_o, .array_oe_i, .in_cell_latch_i, .pin_in_i, .pin_oe_o,
    .open_drain_o, .fast_slew_o, .in_cell_o);
